// ===== rtl/jpgh_dest_map.sv
`timescale 1ns/1ps
module jpgh_dest_map (
	input  wire logic [15:0] pix_col,
	input  wire logic [15:0] pix_line,
	input  wire logic [15:0] size_x,
	input  wire logic [15:0] ax0,
	input  wire logic [15:0] ay0,
	input  wire logic [15:0] ax1,
	input  wire logic [15:0] ay1,
	input  wire logic [15:0] pitch,
	input  wire logic [31:0] base,
	input  wire logic [31:0] limit,
	input  wire logic [31:0] disp,
	output logic             visible,
	output logic             in_window,
	output logic [31:0]      addr
);

	logic        area_on;
	logic [15:0] rcol;
	logic [15:0] rline;
	logic [15:0] len;
	logic [31:0] pos;
	logic [32:0] rel;

	always_comb begin
		area_on = |{ax0, ay0, ax1, ay1};
		rcol    = area_on ? pix_col - ax0 : pix_col;
		rline   = area_on ? pix_line - ay0 : pix_line;
		visible = 1'b1;
		if (area_on)
			visible = pix_col >= ax0 && pix_col <= ax1 &&
				pix_line >= ay0 && pix_line <= ay1;
		if (pitch != 16'h0000) begin
			len = pitch;
			if (rcol >= pitch)
				visible = 1'b0;
		end else if (area_on) begin
			len = ax1 - ax0 + 16'h0001;
		end else begin
			len = size_x;
		end
		pos  = (32'(rline) * 32'(len) + 32'(rcol)) << jpgh_pkg::PIX_SHIFT;
		// image position = disp + ptr - base, so ptr = base + pos - disp
		rel  = {1'b0, pos} - {1'b0, disp};
		addr = base + rel[31:0];
		// a pixel ahead of the displacement is outside the window too
		in_window = !rel[32] && !(addr < base) && (addr < limit);
	end

endmodule : jpgh_dest_map

// ===== rtl/jpgh_pkg.sv
// What this block does
// - read with write-enable low; 4-bit address selects
// - strobe and cycle sampled; data and acknowledge
// - acknowledge is a one-cycle pulse
// - status reads low byte, upper zero
// - interrupt mask reads low byte, upper zero
// - 16-bit registers read zero-extended
// - 32-bit registers read unaltered
// - start bit leaves idle, begins decode
// - done stays ready until next start or soft reset
// - soft reset resets decoder, keeps configuration
// - output limited to area; zeros mean whole
// - input exhausted flag waits for software refill
// - pixel outside window halts, sets full flag
// - nonzero pitch spaces lines, drops overflow pixels
// - current pointer is last offered visible pixel address
// - lines emitted in top-down groups
// - bad data sets decode error flag
// - start and soft reset clear flags
// - horizontal bounds, pitch force bit zero
// - destination addresses forced word aligned
package jpgh_pkg;

	localparam logic [3:0] ADR_STATUS = 4'h0;
	localparam logic [3:0] ADR_MASK   = 4'h1;
	localparam logic [3:0] ADR_SIZE_X = 4'h2;
	localparam logic [3:0] ADR_SIZE_Y = 4'h3;
	localparam logic [3:0] ADR_AX0    = 4'h4;
	localparam logic [3:0] ADR_AY0    = 4'h5;
	localparam logic [3:0] ADR_AX1    = 4'h6;
	localparam logic [3:0] ADR_AY1    = 4'h7;
	localparam logic [3:0] ADR_SRC    = 4'h8;
	localparam logic [3:0] ADR_CNT    = 4'h9;
	localparam logic [3:0] ADR_BASE   = 4'ha;
	localparam logic [3:0] ADR_LIMIT  = 4'hb;
	localparam logic [3:0] ADR_DISP   = 4'hc;
	localparam logic [3:0] ADR_PITCH  = 4'hd;
	localparam logic [3:0] ADR_CUR    = 4'he;

	localparam int BIT_IDLE  = 0;
	localparam int BIT_EXH   = 1;
	localparam int BIT_FULL  = 2;
	localparam int BIT_ERR   = 3;
	localparam int BIT_RDY   = 6;
	localparam int BIT_START = 7;
	localparam int BIT_SRST  = 8;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	localparam int PIX_SHIFT = 1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b11,
		ST_FAIL = 2'b10
	} jpgh_state_type;

endpackage : jpgh_pkg

// ===== rtl/jpgh_regs.sv
`timescale 1ns/1ps
module jpgh_regs (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        stb_i,
	input  wire logic        cyc_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic             ack_o,
	output logic [31:0]      dat_o,
	output logic             irq_o,
	output logic             dec_start,
	output logic             dec_reset,
	input  wire logic        info_valid,
	input  wire logic [15:0] info_width,
	input  wire logic [15:0] info_height,
	input  wire logic        dec_done,
	input  wire logic        dec_error,
	input  wire logic        fetch_want,
	output logic             fetch_valid,
	input  wire logic        fetch_ready,
	output logic [31:0]      fetch_addr,
	input  wire logic        pix_valid,
	output logic             pix_ready,
	input  wire logic [15:0] pix_col,
	input  wire logic [15:0] pix_line,
	input  wire logic [15:0] pix_data,
	output logic             wr_valid,
	input  wire logic        wr_ready,
	output logic [31:0]      wr_addr,
	output logic [15:0]      wr_data
);

	typedef struct packed {
		logic                    ack;
		logic [31:0]             rdat;
		jpgh_pkg::jpgh_state_type st;
		logic [7:0]              mask;
		logic [15:0]             size_x;
		logic [15:0]             size_y;
		logic [15:0]             ax0;
		logic [15:0]             ay0;
		logic [15:0]             ax1;
		logic [15:0]             ay1;
		logic [15:0]             pitch;
		logic [31:0]             src;
		logic [31:0]             cnt;
		logic [31:0]             base;
		logic [31:0]             limit;
		logic [31:0]             disp;
		logic [31:0]             cur;
		logic                    exh;
		logic                    full;
		logic                    err;
		logic                    start_p;
		logic                    srst_p;
	} jpgh_regs_type;

	jpgh_regs_type r_r;
	jpgh_regs_type r_nxt;

	logic        req;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] wval;
	logic [7:0]  status;
	logic        running;
	logic        visible;
	logic        in_window;
	logic [31:0] map_addr;
	logic        buf_ready;
	logic        push;
	logic        fetch_go;
	logic        wr_start;
	logic        wr_srst;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  sel
	);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// a new request is taken only while no acknowledge is out
	assign req    = stb_i & cyc_i & ~r_r.ack;
	assign wr_hit = req & we_i;
	assign rd_hit = req & ~we_i;

	assign wr_start = wr_hit && adr_i == jpgh_pkg::ADR_STATUS &&
		sel_i[0] && dat_i[jpgh_pkg::BIT_START];
	assign wr_srst  = wr_hit && adr_i == jpgh_pkg::ADR_STATUS &&
		sel_i[1] && dat_i[jpgh_pkg::BIT_SRST];

	assign running = (r_r.st == jpgh_pkg::ST_RUN);

	always_comb begin
		// bits 5..4 read zero; start and soft reset are strobes only
		status = 8'h00;
		status[jpgh_pkg::BIT_IDLE] = (r_r.st == jpgh_pkg::ST_IDLE);
		status[jpgh_pkg::BIT_EXH]  = r_r.exh;
		status[jpgh_pkg::BIT_FULL] = r_r.full;
		status[jpgh_pkg::BIT_ERR]  = r_r.err;
		status[jpgh_pkg::BIT_RDY]  = (r_r.st == jpgh_pkg::ST_DONE);
	end

	////////////////////////////////////////////////////////////////////////
	// destination path

	jpgh_dest_map u_map (
		.pix_col   (pix_col),
		.pix_line  (pix_line),
		.size_x    (r_r.size_x),
		.ax0       (r_r.ax0),
		.ay0       (r_r.ay0),
		.ax1       (r_r.ax1),
		.ay1       (r_r.ay1),
		.pitch     (r_r.pitch),
		.base      (r_r.base),
		.limit     (r_r.limit),
		.disp      (r_r.disp),
		.visible   (visible),
		.in_window (in_window),
		.addr      (map_addr)
	);

	// pixels are taken in the engine's order, groups of lines top-down
	always_comb begin
		pix_ready = 1'b0;
		push      = 1'b0;
		if (running && pix_valid && !r_r.full) begin
			if (!visible) begin
				pix_ready = 1'b1;
			end else if (in_window && buf_ready) begin
				pix_ready = 1'b1;
				push      = 1'b1;
			end
		end
	end

	// a stalled writer only holds pixels back, none are lost
	jpgh_skid #(
		.W (48)
	) u_skid (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.in_valid  (push),
		.in_ready  (buf_ready),
		.in_data   ({map_addr, pix_data}),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  ({wr_addr, wr_data})
	);

	////////////////////////////////////////////////////////////////////////
	// source fetch

	assign fetch_valid = running && fetch_want && r_r.cnt != 32'h0000_0000 &&
		!r_r.exh;
	assign fetch_go    = fetch_valid & fetch_ready;
	assign fetch_addr  = r_r.src;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		r_nxt         = r_r;
		r_nxt.start_p = 1'b0;
		r_nxt.srst_p  = 1'b0;
		r_nxt.ack     = req;
		if (r_r.ack)
			r_nxt.ack = 1'b0;
		wval = jpgh_pkg::RST_WORD;

		if (fetch_go) begin
			r_nxt.src = r_r.src + 32'h0000_0001;
			r_nxt.cnt = r_r.cnt - 32'h0000_0001;
		end
		if (info_valid) begin
			r_nxt.size_x = info_width;
			r_nxt.size_y = info_height;
		end
		if (running && pix_valid && visible)
			r_nxt.cur = map_addr;

		if (rd_hit) begin
			case (adr_i)
			jpgh_pkg::ADR_STATUS: r_nxt.rdat = {24'h00_0000, status};
			jpgh_pkg::ADR_MASK:   r_nxt.rdat = {24'h00_0000, r_r.mask};
			jpgh_pkg::ADR_SIZE_X: r_nxt.rdat = {16'h0000, r_r.size_x};
			jpgh_pkg::ADR_SIZE_Y: r_nxt.rdat = {16'h0000, r_r.size_y};
			jpgh_pkg::ADR_AX0:    r_nxt.rdat = {16'h0000, r_r.ax0};
			jpgh_pkg::ADR_AY0:    r_nxt.rdat = {16'h0000, r_r.ay0};
			jpgh_pkg::ADR_AX1:    r_nxt.rdat = {16'h0000, r_r.ax1};
			jpgh_pkg::ADR_AY1:    r_nxt.rdat = {16'h0000, r_r.ay1};
			jpgh_pkg::ADR_PITCH:  r_nxt.rdat = {16'h0000, r_r.pitch};
			jpgh_pkg::ADR_SRC:    r_nxt.rdat = r_r.src;
			jpgh_pkg::ADR_CNT:    r_nxt.rdat = r_r.cnt;
			jpgh_pkg::ADR_BASE:   r_nxt.rdat = r_r.base;
			jpgh_pkg::ADR_LIMIT:  r_nxt.rdat = r_r.limit;
			jpgh_pkg::ADR_DISP:   r_nxt.rdat = r_r.disp;
			jpgh_pkg::ADR_CUR:    r_nxt.rdat = r_r.cur;
			// unmapped index reads zero
			default:              r_nxt.rdat = 32'h0000_0000;
			endcase
		end

		if (wr_hit) begin
			case (adr_i)
			jpgh_pkg::ADR_MASK: begin
				wval = merge({24'h00_0000, r_r.mask}, dat_i, sel_i);
				r_nxt.mask = wval[7:0];
			end
			jpgh_pkg::ADR_AX0: begin
				wval = merge({16'h0000, r_r.ax0}, dat_i, sel_i);
				r_nxt.ax0 = {wval[15:1], 1'b0};
			end
			jpgh_pkg::ADR_AX1: begin
				wval = merge({16'h0000, r_r.ax1}, dat_i, sel_i);
				r_nxt.ax1 = {wval[15:1], 1'b0};
			end
			jpgh_pkg::ADR_PITCH: begin
				wval = merge({16'h0000, r_r.pitch}, dat_i, sel_i);
				r_nxt.pitch = {wval[15:1], 1'b0};
			end
			jpgh_pkg::ADR_AY0: begin
				wval = merge({16'h0000, r_r.ay0}, dat_i, sel_i);
				r_nxt.ay0 = wval[15:0];
			end
			jpgh_pkg::ADR_AY1: begin
				wval = merge({16'h0000, r_r.ay1}, dat_i, sel_i);
				r_nxt.ay1 = wval[15:0];
			end
			// software reload beats a fetch in the same cycle
			jpgh_pkg::ADR_SRC: begin
				r_nxt.src = merge(r_r.src, dat_i, sel_i);
			end
			jpgh_pkg::ADR_CNT: begin
				r_nxt.cnt = merge(r_r.cnt, dat_i, sel_i);
			end
			jpgh_pkg::ADR_BASE: begin
				wval = merge(r_r.base, dat_i, sel_i);
				r_nxt.base = {wval[31:2], 2'b00};
			end
			jpgh_pkg::ADR_LIMIT: begin
				wval = merge(r_r.limit, dat_i, sel_i);
				r_nxt.limit = {wval[31:2], 2'b00};
			end
			jpgh_pkg::ADR_DISP: begin
				wval = merge(r_r.disp, dat_i, sel_i);
				r_nxt.disp = {wval[31:2], 2'b00};
			end
			jpgh_pkg::ADR_STATUS: begin
				if (sel_i[0] && dat_i[jpgh_pkg::BIT_EXH])
					r_nxt.exh = 1'b0;
				if (sel_i[0] && dat_i[jpgh_pkg::BIT_FULL])
					r_nxt.full = 1'b0;
			end
			// read-only and unmapped indices ignore writes
			default: r_nxt.mask = r_r.mask;
			endcase
		end

		// start and soft reset both clear every flag of bits 6..1
		if (wr_start || wr_srst) begin
			r_nxt.exh  = 1'b0;
			r_nxt.full = 1'b0;
			r_nxt.err  = 1'b0;
		end

		// decode sequencing
		case (r_r.st)
		jpgh_pkg::ST_RUN: begin
			if (dec_error)
				r_nxt.st = jpgh_pkg::ST_FAIL;
			else if (dec_done)
				r_nxt.st = jpgh_pkg::ST_DONE;
		end
		jpgh_pkg::ST_IDLE: r_nxt.st = r_r.st;
		jpgh_pkg::ST_DONE: r_nxt.st = r_r.st;
		jpgh_pkg::ST_FAIL: r_nxt.st = r_r.st;
		default:           r_nxt.st = jpgh_pkg::ST_IDLE;
		endcase

		// soft reset outranks start; only the decoder side is reset
		if (wr_srst) begin
			r_nxt.st     = jpgh_pkg::ST_IDLE;
			r_nxt.srst_p = 1'b1;
		end else if (wr_start) begin
			r_nxt.st      = jpgh_pkg::ST_RUN;
			r_nxt.start_p = 1'b1;
		end

		// hardware sets win over a status write clear in the same cycle, not over start or soft reset
		if (running && !wr_start && !wr_srst) begin
			if (fetch_want && r_r.cnt == 32'h0000_0000 && !fetch_go)
				r_nxt.exh = 1'b1;
			if (pix_valid && !r_r.full && visible && !in_window)
				r_nxt.full = 1'b1;
			if (dec_error)
				r_nxt.err = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r_r         <= '0;
			r_r.st      <= jpgh_pkg::ST_IDLE;
			r_r.mask    <= jpgh_pkg::RST_BYTE;
			r_r.pitch   <= jpgh_pkg::RST_HALF;
			r_r.cnt     <= jpgh_pkg::RST_WORD;
			r_r.src     <= jpgh_pkg::RST_WORD;
			r_r.base    <= jpgh_pkg::RST_WORD;
			r_r.limit   <= jpgh_pkg::RST_WORD;
			r_r.disp    <= jpgh_pkg::RST_WORD;
			r_r.cur     <= jpgh_pkg::RST_WORD;
			r_r.ax0     <= jpgh_pkg::RST_HALF;
			r_r.ay0     <= jpgh_pkg::RST_HALF;
			r_r.ax1     <= jpgh_pkg::RST_HALF;
			r_r.ay1     <= jpgh_pkg::RST_HALF;
			r_r.size_x  <= jpgh_pkg::RST_HALF;
			r_r.size_y  <= jpgh_pkg::RST_HALF;
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign ack_o     = r_r.ack;
	assign dat_o     = r_r.rdat;
	assign dec_start = r_r.start_p;
	assign dec_reset = r_r.srst_p;
	assign irq_o     = |(status & r_r.mask);

endmodule : jpgh_regs

// ===== rtl/jpgh_skid.sv
`timescale 1ns/1ps
module jpgh_skid #(
	parameter int W = 48
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	typedef struct packed {
		logic [1:0][W-1:0] slot;
		logic [1:0]        cnt;
	} jpgh_skid_type;

	jpgh_skid_type s_r;
	jpgh_skid_type s_nxt;
	logic          push;
	logic          pop;

	assign in_ready  = (s_r.cnt != 2'd2);
	assign out_valid = (s_r.cnt != 2'd0);
	assign out_data  = s_r.slot[0];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		s_nxt = s_r;
		if (pop) begin
			s_nxt.slot[0] = s_r.slot[1];
		end
		if (push) begin
			// slot 0 holds the head; a pop shifts it out first
			if (s_r.cnt == 2'd0 || (s_r.cnt == 2'd1 && pop))
				s_nxt.slot[0] = in_data;
			else
				s_nxt.slot[1] = in_data;
		end
		case ({push, pop})
		2'b10:   s_nxt.cnt = s_r.cnt + 2'd1;
		2'b01:   s_nxt.cnt = s_r.cnt - 2'd1;
		default: s_nxt.cnt = s_r.cnt;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

endmodule : jpgh_skid

// ===== verif/jpgh_engine_model.sv
`timescale 1ns/1ps
module jpgh_engine_model (
	input  wire logic   sys_clk,
	input  wire logic   sys_rst,
	input  wire logic   dec_start,
	input  wire logic   dec_reset,
	input  wire logic   err_mode,
	input  wire logic   stall_wr,
	input  wire logic   fetch_valid,
	input  wire logic   pix_ready,
	output logic        info_valid,
	output logic [15:0] info_width,
	output logic [15:0] info_height,
	output logic        dec_done,
	output logic        dec_error,
	output logic        fetch_want,
	output logic        fetch_ready,
	output logic        pix_valid,
	output logic [15:0] pix_col,
	output logic [15:0] pix_line,
	output logic [15:0] pix_data,
	output logic        wr_ready
);
	logic       run_r;
	logic [3:0] n_r;
	// four bytes in, four pixels of line 0 out, then finish
	always_ff @(posedge sys_clk) begin
		if (sys_rst || dec_reset) begin
			run_r <= 1'b0;
			n_r   <= 4'h0;
		end else if (dec_start) begin
			run_r <= 1'b1;
			n_r   <= 4'h0;
		end else if (run_r) begin
			if ((fetch_valid && fetch_ready) || (pix_valid && pix_ready))
				n_r <= n_r + 4'h1;
			if (n_r == 4'h8)
				run_r <= 1'b0;
		end
	end
	assign info_valid  = run_r && n_r == 4'h0;
	assign info_width  = 16'h0010;
	assign info_height = 16'h0008;
	assign fetch_want  = run_r && n_r < 4'h4;
	assign fetch_ready = 1'b1;
	assign pix_valid   = run_r && n_r >= 4'h4 && n_r < 4'h8;
	assign pix_col     = pix_valid ? {12'h000, n_r - 4'h4} : 16'hffff;
	assign pix_line    = pix_valid ? 16'h0000 : 16'hffff;
	assign pix_data    = {12'ha50, n_r};
	assign dec_done    = run_r && n_r == 4'h8 && !err_mode;
	assign dec_error   = run_r && n_r == 4'h8 && err_mode;
	assign wr_ready    = !stall_wr;
endmodule : jpgh_engine_model

// ===== verif/jpgh_regs_monitor.sv
`timescale 1ns/1ps
module jpgh_regs_monitor (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        stb_i,
	input wire logic        cyc_i,
	input wire logic        we_i,
	input wire logic [3:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic        ack_o,
	input wire logic [31:0] dat_o,
	input wire logic        dec_start,
	input wire logic        dec_reset,
	input wire logic        fetch_valid,
	input wire logic        fetch_ready,
	input wire logic [31:0] fetch_addr,
	input wire logic        wr_valid,
	input wire logic        wr_ready,
	input wire logic [31:0] wr_addr
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_ack_take;
		stb_i && cyc_i && !ack_o |=> ack_o;
	endproperty
	a_ack_take: assert property (p_ack_take)
		else $error("request not acknowledged");
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("acknowledge longer than one cycle");
	property p_ack_cause;
		ack_o |-> $past(stb_i && cyc_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("acknowledge without request");
	property p_rd_status;
		ack_o && $past(!we_i && adr_i == 4'h0) |-> dat_o[31:8] == 24'h000000;
	endproperty
	a_rd_status: assert property (p_rd_status)
		else $error("status upper bits set");
	property p_rd_mask;
		ack_o && $past(!we_i && adr_i == 4'h1) |-> dat_o[31:8] == 24'h000000;
	endproperty
	a_rd_mask: assert property (p_rd_mask)
		else $error("mask upper bits set");
	property p_rd_half;
		ack_o && $past(!we_i && adr_i inside {[4'h2:4'h7], 4'hd})
			|-> dat_o[31:16] == 16'h0000;
	endproperty
	a_rd_half: assert property (p_rd_half)
		else $error("half register upper bits set");
	property p_rd_src;
		ack_o && $past(!we_i && adr_i == 4'h8) |-> dat_o == $past(fetch_addr);
	endproperty
	a_rd_src: assert property (p_rd_src)
		else $error("source pointer read altered");
	property p_start;
		ack_o && $past(we_i && adr_i == 4'h0 && dat_i[7] && !dat_i[8])
			|-> dec_start;
	endproperty
	a_start: assert property (p_start)
		else $error("start not issued");
	property p_srst;
		ack_o && $past(we_i && adr_i == 4'h0 && dat_i[8]) |-> dec_reset;
	endproperty
	a_srst: assert property (p_srst)
		else $error("soft reset not issued");
	property p_fetch;
		fetch_valid && fetch_ready |=> fetch_addr == $past(fetch_addr) + 32'h1;
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("source pointer did not advance");
	// a stalled word must stay valid with its address unchanged under the writer
	property p_wr_hold;
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("buffered word lost in stall");
	c_start: cover property (dec_start);
	c_fetch: cover property (fetch_valid && fetch_ready);
	c_stall: cover property (wr_valid && !wr_ready);
endmodule : jpgh_regs_monitor
////////////////////////////////////////////////////////////////////////
bind jpgh_regs jpgh_regs_monitor u_mon (.*);

// ===== verif/jpgh_regs_tb_top.sv
`timescale 1ns/1ps
module jpgh_regs_tb_top;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        stb_i = 1'b0;
	logic        cyc_i = 1'b0;
	logic        we_i = 1'b0;
	logic [3:0]  adr_i = 4'h0;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic        err_mode = 1'b0;
	logic        stall_wr = 1'b0;
	logic        ack_o, irq_o, dec_start, dec_reset, info_valid, dec_done;
	logic        dec_error, fetch_want, fetch_valid, fetch_ready, pix_valid;
	logic        pix_ready, wr_valid, wr_ready;
	logic [15:0] info_width, info_height, pix_col, pix_line, pix_data, wr_data;
	logic [31:0] dat_o, fetch_addr, wr_addr, q;
	logic [47:0] wq[$];
	int          fail_count = 0;
	int          cmp_count = 0;
	logic [31:0] tbl [16] = '{32'h0, 32'hff, 32'h0, 32'h0, 32'hfffe, 32'hffff,
		32'hfffe, 32'hffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_fffc,
		32'hffff_fffc, 32'hffff_fffc, 32'hfffe, 32'h0, 32'h0};
	jpgh_regs uut (.*);
	jpgh_engine_model u_eng (.*);
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (wr_valid && wr_ready) wq.push_back({wr_data, wr_addr});
	////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// request held until acknowledge is sampled, then released
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		#1;
		{we_i, adr_i, dat_i, stb_i, cyc_i} = {w, a, d, 2'b11};
		do begin
			@(posedge sys_clk);
			k++;
		end while (ack_o !== 1'b1 && k < 8);
		q = dat_o;
		if (ack_o !== 1'b1) begin
			fail_count++;
			end_of_test();
		end
		#1;
		{stb_i, cyc_i} = 2'b00;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input string n, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(n, q, e);
	endtask : rd
	task automatic run(input logic [31:0] cnt);
		wr(4'h9, cnt);
		wr(4'h0, 32'h80);
	endtask : run
	task automatic wait_flag(input int b);
		int k;
		k = 0;
		q = 32'h0;
		while (q[b] !== 1'b1 && k < 300) begin
			bus(1'b0, 4'h0, 32'h0);
			k++;
		end
		if (q[b] !== 1'b1) begin
			fail_count++;
			end_of_test();
		end
	endtask : wait_flag
	task automatic chk_wq(input int n, input logic [31:0] a,
		input logic [15:0] d);
		check("write count", 32'(wq.size()), 32'(n));
		for (int i = 0; i < n; i++) begin
			check("write address", wq[i][31:0], a + 32'(2 * i));
			check("write data", 32'(wq[i][47:32]), 32'(d) + 32'(i));
		end
		wq.delete();
	endtask : chk_wq
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		rd("status", 4'h0, 32'h1);
		for (int i = 1; i < 16; i++) begin
			wr(i[3:0], 32'hffff_ffff);
			rd("register", i[3:0], tbl[i]);
		end
		check("irq", {31'h0, irq_o}, 32'h1);
		for (int i = 1; i < 14; i++)
			wr(i[3:0], 32'h0);
		check("irq", {31'h0, irq_o}, 32'h0);
		wr(4'h8, 32'h100);
		wr(4'ha, 32'h1000);
		wr(4'hb, 32'h2000);
		wr(4'h1, 32'h40);
		stall_wr = 1'b1;
		run(32'h4);
		repeat (30) @(posedge sys_clk);
		#1;
		check("pixel ready", {31'h0, pix_ready}, 32'h0);
		stall_wr = 1'b0;
		wait_flag(6);
		rd("status", 4'h0, 32'h40);
		check("irq", {31'h0, irq_o}, 32'h1);
		rd("source", 4'h8, 32'h104);
		rd("count", 4'h9, 32'h0);
		rd("width", 4'h2, 32'h10);
		rd("height", 4'h3, 32'h8);
		repeat (20) @(posedge sys_clk);
		chk_wq(4, 32'h1000, 16'ha504);
		wr(4'h1, 32'h2);
		run(32'h2);
		wait_flag(1);
		check("irq", {31'h0, irq_o}, 32'h1);
		rd("source", 4'h8, 32'h106);
		wr(4'h9, 32'h2);
		wr(4'h0, 32'h2);
		wait_flag(6);
		rd("status", 4'h0, 32'h40);
		chk_wq(4, 32'h1000, 16'ha504);
		wr(4'hb, 32'h1004);
		run(32'h4);
		wait_flag(2);
		rd("current", 4'he, 32'h1004);
		wr(4'hb, 32'h2000);
		wr(4'h0, 32'h4);
		wait_flag(6);
		chk_wq(4, 32'h1000, 16'ha504);
		wr(4'h4, 32'h2);
		wr(4'h6, 32'h4);
		run(32'h4);
		wait_flag(6);
		chk_wq(2, 32'h1000, 16'ha506);
		wr(4'h4, 32'h0);
		wr(4'h6, 32'h0);
		wr(4'hd, 32'h2);
		run(32'h4);
		wait_flag(6);
		chk_wq(2, 32'h1000, 16'ha504);
		err_mode = 1'b1;
		wr(4'h8, 32'h300);
		run(32'h4);
		wait_flag(3);
		rd("status", 4'h0, 32'h8);
		wr(4'h0, 32'h100);
		rd("status", 4'h0, 32'h1);
		rd("source", 4'h8, 32'h304);
		sel_i = 4'h2;
		wr(4'h8, 32'hffff_ffff);
		sel_i = 4'hf;
		rd("byte lane", 4'h8, 32'h0000_ff04);
		end_of_test();
	end
endmodule : jpgh_regs_tb_top
